/* File: sbsw_top.sv */
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
// How it works
// R1: access-wait code sets read strobe waits, or first burst read waits.
// R2: shared table: 0-10 linear, then 12,15,20,25,31; both reset to 1111.
// R3: code 0000 ignores the wait input; any other code honours it.
// R4: burst ROM: pitch code sets waits of each later burst access.
// R5: normal memory: pitch code sets write strobe waits.
// R6: bit 15 ignores writes and reads zero.
// R7: recovery field inserts 0-15 idle cycles on bank change or read-to-write.
// R8: memory-type bit 0 selects normal timing, 1 burst ROM; resets 0.
// R9: honoured wait input holds the strobe past the count until released.
module sbsw_top
  import sbsw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire sbsw_req_t   req,
  output logic             req_ready,
  input  wire logic        mem_wait_n,
  output logic             rd_strobe_n,
  output logic             wr_strobe_n,
  output logic             done
);
  logic [31:0]  ctrl;
  logic         aw_held;
  logic         w_held;
  logic [3:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  sbsw_state_t  state;
  logic [4:0]   count;
  logic [3:0]   rec_count;
  logic [1:0]   last_bank;
  logic         last_read;
  logic         have_last;
  logic         cur_write;
  logic         cur_wait_en;

  // ---------------- register bus ----------------
  wire       aw_take   = s_axi_awvalid && s_axi_awready;
  wire       w_take    = s_axi_wvalid && s_axi_wready;
  wire       aw_have   = aw_held || aw_take;
  wire       w_have    = w_held || w_take;
  wire [3:0] wr_addr   = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb   = w_held ? w_strb : s_axi_wstrb;
  wire       wr_fire   = aw_have && w_have && !s_axi_bvalid;
  wire       wr_ctrl   = wr_fire && (wr_addr == SBSW_CTRL_ADDR);
  wire       wr_stat   = wr_addr == SBSW_STAT_ADDR;
  wire [31:0] byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wmask    = byte_mask & SBSW_CTRL_WMASK; // R6
  wire [31:0] next_ctrl = (ctrl & ~wmask) | (wr_data & wmask);
  wire       ar_take   = s_axi_arvalid && s_axi_arready;
  wire       rd_ctrl   = s_axi_araddr == SBSW_CTRL_ADDR;
  wire       rd_stat   = s_axi_araddr == SBSW_STAT_ADDR;
  wire [31:0] stat_word = {26'h000_0000, have_last, last_read, last_bank, state != SBSW_IDLE,
                           rd_strobe_n == 1'b0 || wr_strobe_n == 1'b0};
  wire [31:0] rd_word  = rd_ctrl ? ctrl : (rd_stat ? stat_word : 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl          <= SBSW_CTRL_RST; // R2 R7 R8
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SBSW_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= SBSW_RESP_OKAY;
    end else begin
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held       <= wr_fire ? 1'b0 : aw_have;
      w_held        <= wr_fire ? 1'b0 : w_have;
      s_axi_awready <= !aw_have && !wr_fire && !s_axi_bvalid;
      s_axi_wready  <= !w_have && !wr_fire && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr == SBSW_CTRL_ADDR || wr_stat) ? SBSW_RESP_OKAY
                                                              : SBSW_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (rd_ctrl || rd_stat) ? SBSW_RESP_OKAY : SBSW_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- strobe timing ----------------
  wire       burst_rom  = ctrl[SBSW_MT_BIT]; // R8
  wire [3:0] wait_code  = ctrl[SBSW_WAIT_LSB +: 4];
  wire [3:0] pitch_code = ctrl[SBSW_PITCH_LSB +: 4];
  wire [3:0] rec_code   = ctrl[SBSW_REC_LSB +: 4];
  // burst ROM takes pitch for later beats; normal memory takes it for writes
  wire       use_pitch  = burst_rom ? req.burst_next : req.write; // R1 R4 R5
  wire [3:0] sel_code   = use_pitch ? pitch_code : wait_code;
  wire [4:0] sel_cycles;
  wire       sel_wait_en;
  wire       need_rec   = have_last && ((req.bank != last_bank) || (last_read && req.write)); // R7
  wire       start      = req.valid && req_ready;

  sbsw_decode u_decode (
    .code    (sel_code),
    .cycles  (sel_cycles),
    .wait_en (sel_wait_en)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= SBSW_IDLE;
      count       <= 5'd0;
      rec_count   <= 4'h0;
      last_bank   <= 2'd0;
      last_read   <= 1'b0;
      have_last   <= 1'b0;
      cur_write   <= 1'b0;
      cur_wait_en <= 1'b0;
      req_ready   <= 1'b0;
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      done        <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        SBSW_IDLE: begin
          req_ready <= 1'b1;
          if (start) begin
            req_ready   <= 1'b0;
            cur_write   <= req.write;
            cur_wait_en <= sel_wait_en; // R3
            count       <= sel_cycles;
            last_bank   <= req.bank;
            last_read   <= !req.write;
            have_last   <= 1'b1;
            if (need_rec && rec_code != 4'h0) begin
              rec_count <= rec_code - 4'h1; // R7
              state     <= SBSW_REC;
            end else begin
              rd_strobe_n <= req.write;
              wr_strobe_n <= !req.write;
              state       <= SBSW_STROBE;
            end
          end
        end
        SBSW_REC: begin
          if (rec_count == 4'h0) begin
            rd_strobe_n <= cur_write;
            wr_strobe_n <= !cur_write;
            state       <= SBSW_STROBE;
          end else begin
            rec_count <= rec_count - 4'h1;
          end
        end
        SBSW_STROBE: begin
          if (count != 5'd0) begin
            count <= count - 5'd1;
          end else begin
            state <= SBSW_HOLD;
          end
        end
        SBSW_HOLD: begin
          // an idle wait pin still costs one sample cycle; chosen for a clean pin read
          if (!(cur_wait_en && !mem_wait_n)) begin // R9
            rd_strobe_n <= 1'b1;
            wr_strobe_n <= 1'b1;
            done        <= 1'b1;
            state       <= SBSW_IDLE;
          end
        end
        default: state <= SBSW_IDLE;
      endcase
    end
  end
endmodule

/* File: sbsw_pkg.sv */
package sbsw_pkg;
  // control register byte address on the register bus
  localparam logic [3:0] SBSW_CTRL_ADDR  = 4'h0;
  localparam logic [3:0] SBSW_STAT_ADDR  = 4'h4;
  localparam logic [31:0] SBSW_CTRL_RST  = 32'h0FFF_7700;
  localparam logic [31:0] SBSW_CTRL_WMASK = 32'h0FFF_77CF;
  localparam int SBSW_MT_BIT    = 0;
  localparam int SBSW_PITCH_LSB = 16;
  localparam int SBSW_WAIT_LSB  = 20;
  localparam int SBSW_REC_LSB   = 24;
  localparam logic [1:0] SBSW_RESP_OKAY   = 2'b00;
  localparam logic [1:0] SBSW_RESP_SLVERR = 2'b10;
  localparam logic [4:0] SBSW_CODE_11 = 5'd12;
  localparam logic [4:0] SBSW_CODE_12 = 5'd15;
  localparam logic [4:0] SBSW_CODE_13 = 5'd20;
  localparam logic [4:0] SBSW_CODE_14 = 5'd25;
  localparam logic [4:0] SBSW_CODE_15 = 5'd31;

  typedef enum logic [2:0] {
    SBSW_IDLE   = 3'b000,
    SBSW_STROBE = 3'b001,
    SBSW_HOLD   = 3'b011,
    SBSW_REC    = 3'b010
  } sbsw_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       burst_next;
    logic [1:0] bank;
  } sbsw_req_t;
endpackage

/* File: sbsw_decode.sv */
`timescale 1ns/1ns
module sbsw_decode
  import sbsw_pkg::*;
(
  input  wire logic [3:0] code,
  output logic      [4:0] cycles,
  output logic            wait_en
);
  // non-linear tail of the shared code table
  always_comb begin
    case (code)
      4'hB:    cycles = SBSW_CODE_11; // R2
      4'hC:    cycles = SBSW_CODE_12;
      4'hD:    cycles = SBSW_CODE_13;
      4'hE:    cycles = SBSW_CODE_14;
      4'hF:    cycles = SBSW_CODE_15;
      default: cycles = {1'b0, code};
    endcase
    wait_en = (code != 4'h0); // R3
  end
endmodule

/* File: sbsw_checker.sv */
`timescale 1ns/1ns
module sbsw_checker
  import sbsw_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire sbsw_req_t   req,
  input wire logic        req_ready,
  input wire logic        rd_strobe_n,
  input wire logic        wr_strobe_n,
  input wire logic        done,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take_wr; req.valid && req_ready && req.write; endsequence
  sequence s_take_rd; req.valid && req_ready && !req.write; endsequence
  sequence s_release; $rose(rd_strobe_n) || $rose(wr_strobe_n); endsequence
  // 16 covers the longest recovery gap plus the launch cycle
  chk_wr_launch: assert property (s_take_wr |-> ##[1:16] !wr_strobe_n) else $error("late wr");
  chk_rd_launch: assert property (s_take_rd |-> ##[1:16] !rd_strobe_n) else $error("late rd");
  chk_one_strobe: assert property (rd_strobe_n || wr_strobe_n) else $error("two strobes");
  chk_end_done: assert property (s_release |-> done) else $error("no done");
  chk_done_ready: assert property (done |=> req_ready) else $error("no ready");
  chk_busy_ready: assert property (!(rd_strobe_n && wr_strobe_n) |-> !req_ready)
    else $error("ready while busy");
  chk_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[15] == 1'b0)
    else $error("reserved bit set");
  chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == SBSW_RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000) else $error("error data");
endmodule
bind sbsw_top sbsw_checker sbsw_checker_i (.aclk, .aresetn, .req, .req_ready, .rd_strobe_n,
  .wr_strobe_n, .done, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata);

/* File: sbsw_mem_model.sv */
`timescale 1ns/1ns
module sbsw_mem_model (
  input  wire logic       aclk,
  input  wire logic       rd_strobe_n,
  input  wire logic       wr_strobe_n,
  input  wire logic [4:0] stall,
  output logic            mem_wait_n
);
  logic [5:0] cnt = 6'h00;
  always @(posedge aclk) begin
    if (rd_strobe_n && wr_strobe_n) cnt <= 6'h00;
    else if (cnt != 6'h3F) cnt <= cnt + 6'h01;
  end
  // pulled up: the wait line rests high outside a strobe
  assign mem_wait_n = (rd_strobe_n && wr_strobe_n) || (cnt >= {1'b0, stall});
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
  import sbsw_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic req_ready, mem_wait_n, rd_strobe_n, wr_strobe_n, done;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
  logic [4:0]  stall;
  sbsw_req_t   req;
  int          err_total, checks, base, bw, len, oth, tot, g;
  sbsw_top sbsw_top_i (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .req           (req),
    .req_ready     (req_ready),
    .mem_wait_n    (mem_wait_n),
    .rd_strobe_n   (rd_strobe_n),
    .wr_strobe_n   (wr_strobe_n),
    .done          (done)
  );
  sbsw_mem_model sbsw_mem_model_i (.aclk, .rd_strobe_n, .wr_strobe_n, .stall, .mem_wait_n);
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ta = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        tw = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    b = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic acc(input logic w, input logic bn, input logic [1:0] bk);
    req <= '{1'b1, w, bn, bk};
    do @(posedge aclk); while (req_ready !== 1'b1);
    req.valid <= 1'b0;
    len = 0;
    oth = 0;
    tot = 0;
    do begin
      @(posedge aclk);
      tot++;
      len += w ? !wr_strobe_n : !rd_strobe_n;
      oth += w ? !rd_strobe_n : !wr_strobe_n;
    end while (done !== 1'b1);
    chk(oth, 0);
  endtask
  function automatic int tbl(input int c);
    tbl = c < 11 ? c : c == 11 ? 12 : c == 12 ? 15 : c == 13 ? 20 : c == 14 ? 25 : 31;
  endfunction
  function automatic logic [31:0] cw(input int rc, input int aw, input int bp, input logic mt);
    cw = {4'h0, 4'(rc), 4'(aw), 4'(bp), 15'h0000, mt};
  endfunction
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_regs;
    rd(SBSW_CTRL_ADDR);
    chk(d, 32'h0FFF_7700);
    wr(SBSW_CTRL_ADDR, 32'hFFFF_FFFF);
    chk(b, SBSW_RESP_OKAY);
    rd(SBSW_CTRL_ADDR);
    chk(d[15], 0);
    chk(d, 32'h0FFF_77CF);
    // only byte lane 2 enabled: access-wait and pitch clear, the rest stays
    s_axi_wstrb <= 4'h4;
    wr(SBSW_CTRL_ADDR, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    rd(SBSW_CTRL_ADDR);
    chk(d, 32'h0F00_77CF);
    wr(4'h8, 32'h0000_0000);
    chk(b, SBSW_RESP_SLVERR);
    wr(SBSW_STAT_ADDR, 32'hFFFF_FFFF);
    chk(b, SBSW_RESP_OKAY);
    rd(4'h8);
    chk(r, SBSW_RESP_SLVERR);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_table;
    for (int c = 0; c < 16; c++) begin
      wr(SBSW_CTRL_ADDR, cw(0, c, c, 0));
      acc(0, 0, 0);
      if (c == 0) base = len;
      else chk(len, base + tbl(c));
      acc(1, 0, 0);
      if (c == 0) bw = len;
      else chk(len, bw + tbl(c));
    end
  endtask
  task automatic t_burst;
    wr(SBSW_CTRL_ADDR, cw(0, 0, 5, 1));
    acc(0, 0, 0);
    chk(len, base);
    acc(0, 1, 0);
    chk(len, base + 5);
    wr(SBSW_CTRL_ADDR, cw(0, 0, 5, 0));
    acc(0, 1, 0);
    chk(len, base);
  endtask
  task automatic t_wait;
    stall <= 5'd10;
    wr(SBSW_CTRL_ADDR, cw(0, 0, 0, 0));
    acc(0, 0, 0);
    chk(len, base);
    wr(SBSW_CTRL_ADDR, cw(0, 1, 0, 0));
    acc(0, 0, 0);
    chk(len > base + 1 && len <= base + 12, 1);
    stall <= 5'd0;
  endtask
  task automatic t_rec;
    wr(SBSW_CTRL_ADDR, cw(4, 0, 0, 0));
    acc(0, 0, 0);
    acc(0, 0, 0);
    g = tot - len;
    acc(0, 0, 1);
    chk(tot - len, g + 4);
    acc(1, 0, 1);
    chk(tot - len, g + 4);
    // write then read in the same bank needs no idle gap
    acc(0, 0, 1);
    chk(tot - len, g);
    rd(SBSW_STAT_ADDR);
    chk(d, 32'h0000_0034);
  endtask
  task automatic t_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(SBSW_CTRL_ADDR);
    chk(d, SBSW_CTRL_RST);
    rd(SBSW_STAT_ADDR);
    chk(d, 32'h0000_0000);
    // history is cleared, so a bank change right after reset costs no gap
    acc(0, 0, 2);
    chk(tot - len, g);
  endtask
  initial begin
    aresetn = 0;
    req = '0;
    stall = 0;
    s_axi_awvalid = 0;
    s_axi_wvalid = 0;
    s_axi_arvalid = 0;
    s_axi_bready = 1;
    s_axi_rready = 1;
    s_axi_wstrb = 4'hF;
    s_axi_awaddr = 0;
    s_axi_araddr = 0;
    s_axi_wdata = 0;
    err_total = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_table();
    t_burst();
    t_wait();
    t_rec();
    t_reset();
    print_verdict();
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule
